// *** core/lais_pkg.sv ***
/*
  Shared constants for the limit alarm and interval alignment block:
  register map, field positions, reset values, selector codes, timing.
  Assumes a 125 MHz system clock and an AHB-Lite register bus.
*/
package lais_pkg;

  localparam int unsigned LAIS_NUM_MON = 4;
  localparam int unsigned LAIS_VAL_W = 16;
  localparam int unsigned LAIS_TIM_W = 16;

  // One second of wall time expressed in clock cycles
  localparam longint unsigned LAIS_SEC_NS = 1000000000;
  localparam longint unsigned LAIS_CLK_NS = 8;
  localparam int unsigned LAIS_CLKS_PER_SEC =
    int'(LAIS_SEC_NS / LAIS_CLK_NS);

  // Selector switch codes
  localparam logic [2:0] LAIS_SEL_VIEW1 = 3'h0;
  localparam logic [2:0] LAIS_SEL_VIEW4 = 3'h3;
  localparam logic [2:0] LAIS_SEL_POWER = 3'h4;

  // Register byte offsets
  localparam logic [7:0] LAIS_A_CTRL = 8'h00;
  localparam logic [7:0] LAIS_A_STAT = 8'h04;
  localparam logic [7:0] LAIS_A_CYCLE = 8'h08;
  localparam logic [7:0] LAIS_A_INTV = 8'h0C;
  localparam logic [7:0] LAIS_A_PERD = 8'h10;
  localparam logic [7:0] LAIS_A_TIMERS = 8'h14;
  localparam logic [7:0] LAIS_A_LIMLO = 8'h20;
  localparam logic [7:0] LAIS_A_LIMHI = 8'h30;
  localparam logic [7:0] LAIS_A_STRIDE = 8'h04;

  // Control fields
  localparam int unsigned LAIS_CTRL_PRN = 0;
  localparam int unsigned LAIS_CTRL_EXT = 1;
  localparam int unsigned LAIS_CTRL_MSYNC = 2;

  // Status fields
  localparam int unsigned LAIS_ST_ALARM = 0;
  localparam int unsigned LAIS_ST_ALIGNED = 1;
  localparam int unsigned LAIS_ST_WAIT = 2;
  localparam int unsigned LAIS_ST_ARMED = 3;
  localparam int unsigned LAIS_ST_RUN = 4;
  localparam int unsigned LAIS_ST_PEND = 5;

  // Reset values
  localparam logic [LAIS_TIM_W-1:0] LAIS_CYCLE_RST = 16'h0001;
  localparam logic [LAIS_TIM_W-1:0] LAIS_INTV_RST = 16'h003C;
  localparam logic [LAIS_TIM_W-1:0] LAIS_PERD_RST = 16'h003C;
  localparam logic [LAIS_VAL_W-1:0] LAIS_LIMLO_RST = 16'h0000;
  localparam logic [LAIS_VAL_W-1:0] LAIS_LIMHI_RST = 16'hFFFF;

  // AHB-Lite codes
  localparam logic [1:0] LAIS_HTRANS_NONSEQ = 2'h2;
  localparam logic LAIS_HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    LAIS_OK = 2'b01,
    LAIS_ALM = 2'b10
  } lais_alm_t;

endpackage

// *** core/lais_top.sv ***
/*
  Limit alarm and interval/period timer alignment, with AHB-Lite registers.
  Assumes measured values arrive on clk_sys; selector, trigger and printer
  busy come from outside and are synchronised here.
*/
module lais_top
  import lais_pkg::*;
#(
  parameter int unsigned CLKS_PER_SEC = LAIS_CLKS_PER_SEC
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [LAIS_VAL_W-1:0] meas_val0,
  input wire logic [LAIS_VAL_W-1:0] meas_val1,
  input wire logic [LAIS_VAL_W-1:0] meas_val2,
  input wire logic [LAIS_VAL_W-1:0] meas_val3,
  input wire logic [2:0] sel_pos_pin,
  input wire logic sync_pin,
  input wire logic printer_busy_pin,
  output logic relay_c12_closed,
  output logic relay_c23_closed,
  output logic print_req,
  output logic print_alarm_tag,
  output logic waiting_ind,
  output logic series_run,
  output logic card_rec_en
);

  localparam int PRE_W = $clog2(CLKS_PER_SEC + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CLKS_PER_SEC - 1);

  function automatic logic out_of_band(input logic [LAIS_VAL_W-1:0] v,
    input logic [LAIS_VAL_W-1:0] lo, input logic [LAIS_VAL_W-1:0] hi);
    return (v < lo) || (v > hi);
  endfunction

  function automatic logic ratio_ok(input logic [LAIS_TIM_W-1:0] iv,
    input logic [LAIS_TIM_W-1:0] pd);
    return (iv != '0) && (pd != '0) && ((pd % iv) == '0);
  endfunction

  function automatic logic [LAIS_TIM_W-1:0] wrap_inc(
    input logic [LAIS_TIM_W-1:0] t, input logic [LAIS_TIM_W-1:0] len);
    return (t + 16'h0001 >= len) ? '0 : LAIS_TIM_W'(t + 16'h0001);
  endfunction

  // Bus and register state
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic ctrl_prn_q, ctrl_ext_q, msync_q;
  logic [LAIS_TIM_W-1:0] cycle_q, intv_q, perd_q;
  logic [LAIS_VAL_W-1:0] lim_lo_q [LAIS_NUM_MON];
  logic [LAIS_VAL_W-1:0] lim_hi_q [LAIS_NUM_MON];
  logic [LAIS_VAL_W-1:0] vals [LAIS_NUM_MON];
  logic [31:0] rd_data;
  logic addr_ph, wr_ctrl, wr_intv, wr_perd, setting_chg, ext_rise_w;

  // Synchronisers: first stage is read only by the second
  logic [2:0] sel_s1_q, sel_s2_q;
  logic sync_s1_q, sync_s2_q, sync_s3_q;
  logic busy_s1_q, busy_s2_q, busy_s3_q;
  logic trig_rise, busy_fall;

  // Timing
  logic [PRE_W-1:0] pre_q;
  logic sec_tick;
  logic [LAIS_TIM_W-1:0] cyc_cnt_q, int_t_q, per_t_q;
  logic cyc_tick;

  // Alarm and alignment
  lais_alm_t st_q;
  logic viol, mon_en, pos_ok, pend_q;
  logic armed_q, aligned_q, man_align, ext_align, do_align;
  logic relay_c12_q, relay_c23_q, print_req_q, print_tag_q;
  logic waiting_q, series_q, card_q;

  assign vals[0] = meas_val0;
  assign vals[1] = meas_val1;
  assign vals[2] = meas_val2;
  assign vals[3] = meas_val3;

  // ---------------- AHB-Lite slave, zero wait states ----------------
  assign addr_ph = hsel && hready && (htrans == LAIS_HTRANS_NONSEQ);
  assign wr_ctrl = wr_pend_q && (wr_addr_q == LAIS_A_CTRL);
  assign wr_intv = wr_pend_q && (wr_addr_q == LAIS_A_INTV);
  assign wr_perd = wr_pend_q && (wr_addr_q == LAIS_A_PERD);
  assign setting_chg = (wr_intv && hwdata[LAIS_TIM_W-1:0] != intv_q) ||
                       (wr_perd && hwdata[LAIS_TIM_W-1:0] != perd_q);
  assign ext_rise_w = wr_ctrl && hwdata[LAIS_CTRL_EXT] && !ctrl_ext_q;

  always_comb
  begin
    rd_data = '0;
    unique case (haddr[7:0])
      LAIS_A_CTRL:
      begin
        rd_data[LAIS_CTRL_PRN] = ctrl_prn_q;
        rd_data[LAIS_CTRL_EXT] = ctrl_ext_q;
      end
      LAIS_A_STAT:
      begin
        rd_data[LAIS_ST_ALARM] = (st_q == LAIS_ALM);
        rd_data[LAIS_ST_ALIGNED] = aligned_q;
        rd_data[LAIS_ST_WAIT] = waiting_q;
        rd_data[LAIS_ST_ARMED] = armed_q;
        rd_data[LAIS_ST_RUN] = series_q;
        rd_data[LAIS_ST_PEND] = pend_q;
      end
      LAIS_A_CYCLE: rd_data[LAIS_TIM_W-1:0] = cycle_q;
      LAIS_A_INTV: rd_data[LAIS_TIM_W-1:0] = intv_q;
      LAIS_A_PERD: rd_data[LAIS_TIM_W-1:0] = perd_q;
      LAIS_A_TIMERS: rd_data = {per_t_q, int_t_q};
      default:
      begin
        for (int i = 0; i < LAIS_NUM_MON; i++)
        begin
          if (haddr[7:0] == 8'(LAIS_A_LIMLO + LAIS_A_STRIDE * i))
            rd_data[LAIS_VAL_W-1:0] = lim_lo_q[i];
          if (haddr[7:0] == 8'(LAIS_A_LIMHI + LAIS_A_STRIDE * i))
            rd_data[LAIS_VAL_W-1:0] = lim_hi_q[i];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= '0;
    end
    else
    begin
      wr_pend_q <= addr_ph && hwrite;
      if (addr_ph)
        wr_addr_q <= haddr[7:0];
      if (addr_ph && !hwrite)
        hrdata_q <= rd_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ctrl_prn_q <= 1'b0;
      ctrl_ext_q <= 1'b0;
      msync_q <= 1'b0;
      cycle_q <= LAIS_CYCLE_RST;
      intv_q <= LAIS_INTV_RST;
      perd_q <= LAIS_PERD_RST;
      for (int i = 0; i < LAIS_NUM_MON; i++)
      begin
        lim_lo_q[i] <= LAIS_LIMLO_RST;
        lim_hi_q[i] <= LAIS_LIMHI_RST;
      end
    end
    else
    begin
      msync_q <= wr_ctrl && hwdata[LAIS_CTRL_MSYNC];
      if (wr_ctrl)
      begin
        ctrl_prn_q <= hwdata[LAIS_CTRL_PRN];
        ctrl_ext_q <= hwdata[LAIS_CTRL_EXT];
      end
      if (wr_pend_q && wr_addr_q == LAIS_A_CYCLE)
        cycle_q <= hwdata[LAIS_TIM_W-1:0];
      if (wr_intv)
        intv_q <= hwdata[LAIS_TIM_W-1:0];
      if (wr_perd)
        perd_q <= hwdata[LAIS_TIM_W-1:0];
      for (int i = 0; i < LAIS_NUM_MON; i++)
      begin
        if (wr_pend_q && wr_addr_q == 8'(LAIS_A_LIMLO + LAIS_A_STRIDE * i))
          lim_lo_q[i] <= hwdata[LAIS_VAL_W-1:0];
        if (wr_pend_q && wr_addr_q == 8'(LAIS_A_LIMHI + LAIS_A_STRIDE * i))
          lim_hi_q[i] <= hwdata[LAIS_VAL_W-1:0];
      end
    end
  end

  // ---------------- Input synchronisers ----------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      sel_s1_q <= '0;
      sel_s2_q <= '0;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_s3_q <= 1'b0;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      busy_s3_q <= 1'b0;
    end
    else
    begin
      sel_s1_q <= sel_pos_pin;
      sel_s2_q <= sel_s1_q;
      sync_s1_q <= sync_pin;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
      busy_s1_q <= printer_busy_pin;
      busy_s2_q <= busy_s1_q;
      busy_s3_q <= busy_s2_q;
    end
  end

  // Trigger on rising edge only; the source's half-second hold is not policed
  assign trig_rise = sync_s2_q && !sync_s3_q;
  assign busy_fall = !busy_s2_q && busy_s3_q;

  // ---------------- Second and cycle ticks ----------------
  assign sec_tick = (pre_q == PRE_LAST);
  // A zero cycle time behaves as one second
  assign cyc_tick = sec_tick && (cyc_cnt_q + 16'h0001 >= cycle_q);

  always_ff @(posedge clk_sys)
  begin
    if (!rstn || do_align)
      pre_q <= '0;
    else
      pre_q <= sec_tick ? '0 : PRE_W'(pre_q + 1'b1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      cyc_cnt_q <= '0;
    else if (sec_tick)
      cyc_cnt_q <= cyc_tick ? '0 : LAIS_TIM_W'(cyc_cnt_q + 16'h0001);
  end

  // ---------------- Limit monitoring ----------------
  assign mon_en = (sel_s2_q == LAIS_SEL_VIEW4);

  always_comb
  begin
    viol = 1'b0;
    for (int i = 0; i < LAIS_NUM_MON; i++)
      viol = viol || out_of_band(vals[i], lim_lo_q[i], lim_hi_q[i]);
  end

  // Alarm print still running: set on request, cleared when busy drops
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      pend_q <= 1'b0;
    else if (st_q == LAIS_OK && mon_en && cyc_tick && viol && ctrl_prn_q)
      pend_q <= 1'b1;
    else if (busy_fall)
      pend_q <= 1'b0;
  end

  // Sampling only on cycle ticks: shorter excursions are missed
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st_q <= LAIS_OK;
      relay_c12_q <= 1'b1;
      relay_c23_q <= 1'b0;
      print_req_q <= 1'b0;
      print_tag_q <= 1'b0;
    end
    else
    begin
      print_req_q <= 1'b0;
      unique case (st_q)
        LAIS_OK:
        begin
          if (mon_en && cyc_tick && viol)
          begin
            st_q <= LAIS_ALM;
            relay_c12_q <= 1'b0;
            relay_c23_q <= 1'b1;
            print_req_q <= ctrl_prn_q;
            print_tag_q <= 1'b1;
          end
        end
        LAIS_ALM:
        begin
          if (!mon_en)
          begin
            st_q <= LAIS_OK;
            relay_c12_q <= 1'b1;
            relay_c23_q <= 1'b0;
          end
          else if (cyc_tick && !viol)
          begin
            st_q <= LAIS_OK;
            relay_c12_q <= 1'b1;
            relay_c23_q <= 1'b0;
            print_req_q <= ctrl_prn_q && !pend_q;
            print_tag_q <= 1'b0;
          end
        end
        default:
        begin
          st_q <= LAIS_OK;
          relay_c12_q <= 1'b1;
          relay_c23_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- Timer alignment ----------------
  assign pos_ok = (sel_s2_q >= LAIS_SEL_VIEW1) &&
                  (sel_s2_q <= LAIS_SEL_POWER);
  assign man_align = msync_q && !ctrl_ext_q && pos_ok &&
                     ratio_ok(intv_q, perd_q);
  assign ext_align = trig_rise && ctrl_ext_q && armed_q && pos_ok &&
                     ratio_ok(intv_q, perd_q);
  assign do_align = man_align || ext_align;

  // Armed on each switch to external, spent by the first trigger that aligns
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      armed_q <= 1'b0;
    else if (ext_rise_w)
      armed_q <= 1'b1;
    else if (ext_align || !ctrl_ext_q)
      armed_q <= 1'b0;
  end

  // A setting change in the align cycle wins: old lengths were used
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || setting_chg)
      aligned_q <= 1'b0;
    else if (do_align)
      aligned_q <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn || do_align)
    begin
      int_t_q <= '0;
      per_t_q <= '0;
    end
    else if (sec_tick)
    begin
      int_t_q <= wrap_inc(int_t_q, intv_q);
      per_t_q <= wrap_inc(per_t_q, perd_q);
    end
  end

  // Card gating uses the view-four selector and trigger wait, never the alarm path
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      waiting_q <= 1'b0;
      series_q <= 1'b0;
      card_q <= 1'b0;
    end
    else
    begin
      waiting_q <= ctrl_ext_q && armed_q && pos_ok;
      series_q <= pos_ok && !(ctrl_ext_q && armed_q);
      card_q <= mon_en && !(ctrl_ext_q && armed_q);
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = LAIS_HRESP_OKAY;
  assign relay_c12_closed = relay_c12_q;
  assign relay_c23_closed = relay_c23_q;
  assign print_req = print_req_q;
  assign print_alarm_tag = print_tag_q;
  assign waiting_ind = waiting_q;
  assign series_run = series_q;
  assign card_rec_en = card_q;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_first_viol;
    st_q == LAIS_OK && mon_en && cyc_tick && viol;
  endsequence

  sequence s_recover;
    st_q == LAIS_ALM && mon_en && cyc_tick && !viol;
  endsequence

  a_alarm_assert: assert property (s_first_viol |=>
    relay_c23_closed && !relay_c12_closed && st_q == LAIS_ALM)
    else $error("alarm not raised on violation");
  a_alarm_release: assert property (s_recover |=>
    relay_c12_closed && !relay_c23_closed)
    else $error("alarm not released on recovery");
  a_contact_pair: assert property (
    relay_c12_closed == !relay_c23_closed &&
    relay_c23_closed == (st_q == LAIS_ALM))
    else $error("contact pairs disagree with alarm");
  a_alarm_print: assert property (s_first_viol ##0 ctrl_prn_q |=>
    print_req && print_alarm_tag)
    else $error("missing tagged alarm print");
  a_no_reprint: assert property (
    st_q == LAIS_ALM ##1 st_q == LAIS_ALM |-> !print_req)
    else $error("print requested during active alarm");
  a_recover_print: assert property (
    s_recover ##0 (ctrl_prn_q && !pend_q) |=> print_req && !print_alarm_tag)
    else $error("missing untagged recovery print");
  a_recover_hush: assert property (s_recover ##0 pend_q |=>
    !print_req)
    else $error("recovery print not suppressed");
  a_sel_exit: assert property (!mon_en |=> st_q == LAIS_OK)
    else $error("monitoring active outside view four");
  a_cycle_eval: assert property ($rose(relay_c23_closed) |->
    $past(cyc_tick))
    else $error("alarm changed off the cycle tick");
  a_align_zero: assert property (do_align |=>
    int_t_q == '0 && per_t_q == '0 && (aligned_q || $past(setting_chg)))
    else $error("timers not cleared by alignment");
  a_align_gate: assert property (do_align |->
    pos_ok && intv_q != '0 && (perd_q % intv_q) == '0)
    else $error("alignment outside allowed conditions");
  a_unaligned: assert property (setting_chg |=> !aligned_q)
    else $error("still aligned after setting change");
  a_ext_once: assert property (
    ctrl_ext_q && !armed_q && !ext_rise_w |=> !armed_q [*2])
    else $error("external trigger re-armed without mode change");
  a_wait_hold: assert property (waiting_ind |-> !series_run &&
    !card_rec_en)
    else $error("series running while waiting for trigger");

endmodule

// *** testbench/lais_partner.sv ***
/*
  Far-side model: a printer module that turns busy after each print
  request, and an isolated trigger source on the external sync input.
  Assumes the bench sets the busy span and pulses trig_go for one cycle.
*/
module lais_partner
#(
  parameter int unsigned HOLD = 5
)
(
  input wire logic clk_sys,
  input wire logic print_req,
  input wire logic trig_go,
  input wire logic [31:0] busy_len,
  output logic printer_busy_pin,
  output logic sync_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy_cnt = 32'h0;
  int hold_cnt = 0;

  // Printer starts two cycles late, like a real mechanism spinning up
  always @(posedge clk_sys)
  begin
    if (print_req === 1'b1)
      busy_cnt <= busy_len + 32'h2;
    else if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 32'h1;
  end

  always @(posedge clk_sys)
  begin
    if (trig_go === 1'b1)
      hold_cnt <= HOLD;
    else if (hold_cnt > 0)
      hold_cnt <= hold_cnt - 1;
  end

  assign printer_busy_pin = (busy_cnt > 0) && (busy_cnt <= busy_len);
  // Optocoupler off between pulses, so the pin idles low
  assign sync_pin = (hold_cnt > 0);
endmodule

// *** testbench/lais_tb_top.sv ***
/*
  Self-checking bench for lais_top: bus register checks, limit alarm,
  print requests and interval/period alignment.
  Assumes lais_partner as printer and trigger source, one 8 ns clock.
*/
module lais_tb_top
  import lais_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CPS = 10;
  localparam logic [15:0] LO = 16'h0064;
  localparam logic [15:0] HI = 16'h00C8;
  logic clk_sys;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [LAIS_VAL_W-1:0] mv [4];
  logic [2:0] sel = LAIS_SEL_VIEW1;
  logic sync_pin;
  logic busy_pin;
  logic c12;
  logic c23;
  logic print_req;
  logic prn_tag;
  logic waiting_ind;
  logic series_run;
  logic card_rec_en;
  logic trig_go = 1'b0;
  logic [31:0] busy_len = 32'h5;
  logic [31:0] rnd = 32'hFBD4;
  logic rd_ph = 1'b0;
  int error_cnt = 0;
  int n_compared = 0;
  int i;
  logic [31:0] exp_rd [$];
  logic [31:0] msk_rd [$];
  logic exp_prn [$];

  assign hready = hreadyout;

  lais_top #(.CLKS_PER_SEC(CPS)) uut (.clk_sys(clk_sys), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_val0(mv[0]),
    .meas_val1(mv[1]), .meas_val2(mv[2]), .meas_val3(mv[3]),
    .sel_pos_pin(sel), .sync_pin(sync_pin), .printer_busy_pin(busy_pin),
    .relay_c12_closed(c12), .relay_c23_closed(c23),
    .print_req(print_req), .print_alarm_tag(prn_tag),
    .waiting_ind(waiting_ind), .series_run(series_run),
    .card_rec_en(card_rec_en));

  lais_partner #(.HOLD(CPS / 2)) far (.clk_sys(clk_sys),
    .print_req(print_req), .trig_go(trig_go), .busy_len(busy_len),
    .printer_busy_pin(busy_pin), .sync_pin(sync_pin));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Value from base up to base+63, drawn from the shift register
  function logic [15:0] rv(input logic [15:0] base);
    rnd = lfsr(rnd);
    return base + {10'h0, rnd[5:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // Waits as long as the slave stalls; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= LAIS_HTRANS_NONSEQ;
    do
      @(posedge clk_sys);
    while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge clk_sys);
    while (hready !== 1'b1);
  endtask

  // Settling gap so a write's side effects are visible to the next read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    cyc(3);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_rd.push_back(e);
    msk_rd.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic trig;
    trig_go <= 1'b1;
    @(posedge clk_sys);
    trig_go <= 1'b0;
    cyc(8);
  endtask

  // Watches the ports and retires the oldest note per result
  always @(posedge clk_sys)
  begin
    if (rd_ph && hready === 1'b1)
      chk(hrdata & msk_rd.pop_front(), exp_rd.pop_front());
    if (hready === 1'b1)
      rd_ph <= hsel && (htrans == LAIS_HTRANS_NONSEQ) && !hwrite;
    if (print_req === 1'b1)
      chk({31'h0, prn_tag}, exp_prn.size() > 0 ?
        {31'h0, exp_prn.pop_front()} : 32'h2);
    // Relay flops are unknown until the first reset edge
    if (rstn === 1'b1)
      chk({31'h0, c12 ^ c23}, 32'h1);
  end

  initial
  begin
    mv = '{LO, LO, LO, LO};
    cyc(3);
    rstn <= 1'b1;
    rd(LAIS_A_CYCLE, 32'h1, 32'hFFFFFFFF);
    rd(LAIS_A_INTV, 32'h3C, 32'hFFFFFFFF);
    rd(LAIS_A_PERD, 32'h3C, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0, 32'hFFFFFFFF);
    rd(LAIS_A_STAT, 32'h0, 32'h2);
    for (i = 0; i < 4; i++)
    begin
      rd(LAIS_A_LIMLO + 8'(4 * i), 32'h0, 32'hFFFFFFFF);
      rd(LAIS_A_LIMHI + 8'(4 * i), 32'hFFFF, 32'hFFFFFFFF);
      wr(LAIS_A_LIMLO + 8'(4 * i), {16'h0, LO});
      wr(LAIS_A_LIMHI + 8'(4 * i), {16'h0, HI});
      rd(LAIS_A_LIMHI + 8'(4 * i), {16'h0, HI}, 32'hFFFFFFFF);
    end
    wr(LAIS_A_CTRL, 32'h1);
    sel <= LAIS_SEL_VIEW4;
    mv[1] <= rv(LO);
    cyc(25);
    chk({31'h0, c12}, 32'h1);
    exp_prn.push_back(1'b1);
    mv[0] <= rv(HI + 16'h1);
    cyc(25);
    chk({31'h0, c23}, 32'h1);
    chk({31'h0, card_rec_en}, 32'h1);
    mv[2] <= rv(16'h0);
    cyc(25);
    mv[0] <= rv(LO);
    cyc(25);
    chk({31'h0, c23}, 32'h1);
    exp_prn.push_back(1'b0);
    mv[2] <= rv(LO);
    cyc(25);
    chk({31'h0, c12}, 32'h1);
    busy_len <= 32'd60;
    exp_prn.push_back(1'b1);
    mv[1] <= rv(HI + 16'h1);
    i = 0;
    while (c23 !== 1'b1 && i < 30)
    begin
      @(posedge clk_sys);
      i++;
    end
    chk({31'h0, c23}, 32'h1);
    mv[1] <= rv(LO);
    cyc(100);
    chk({31'h0, c12}, 32'h1);
    busy_len <= 32'h5;
    exp_prn.push_back(1'b1);
    mv[3] <= rv(HI + 16'h1);
    cyc(25);
    chk({31'h0, c23}, 32'h1);
    sel <= LAIS_SEL_VIEW1;
    cyc(8);
    chk({31'h0, c12}, 32'h1);
    cyc(25);
    chk({31'h0, c12}, 32'h1);
    mv[3] <= rv(LO);
    sel <= LAIS_SEL_POWER;
    cyc(4);
    rd(LAIS_A_STAT, 32'h0, 32'h2);
    wr(LAIS_A_CTRL, 32'h5);
    rd(LAIS_A_STAT, 32'h2, 32'h2);
    rd(LAIS_A_TIMERS, 32'h0, 32'hFFFFFFFF);
    cyc(35);
    wr(LAIS_A_CTRL, 32'h5);
    rd(LAIS_A_TIMERS, 32'h0, 32'hFFFFFFFF);
    wr(LAIS_A_PERD, 32'h3D);
    rd(LAIS_A_STAT, 32'h0, 32'h2);
    wr(LAIS_A_CTRL, 32'h5);
    rd(LAIS_A_STAT, 32'h0, 32'h2);
    wr(LAIS_A_PERD, 32'h78);
    wr(LAIS_A_CTRL, 32'h5);
    rd(LAIS_A_STAT, 32'h2, 32'h2);
    wr(LAIS_A_INTV, 32'h28);
    sel <= 3'h5;
    cyc(4);
    wr(LAIS_A_CTRL, 32'h5);
    rd(LAIS_A_STAT, 32'h0, 32'h2);
    sel <= LAIS_SEL_VIEW1;
    cyc(4);
    wr(LAIS_A_CTRL, 32'h5);
    rd(LAIS_A_STAT, 32'h2, 32'h2);
    wr(LAIS_A_CTRL, 32'h3);
    chk({31'h0, waiting_ind}, 32'h1);
    chk({31'h0, series_run}, 32'h0);
    trig();
    chk({31'h0, waiting_ind}, 32'h0);
    chk({31'h0, series_run}, 32'h1);
    // Timers read first, before the first second after alignment ends
    rd(LAIS_A_TIMERS, 32'h0, 32'hFFFFFFFF);
    rd(LAIS_A_STAT, 32'h2, 32'h2);
    wr(LAIS_A_INTV, 32'h3C);
    trig();
    rd(LAIS_A_STAT, 32'h0, 32'h2);
    wr(LAIS_A_CTRL, 32'h1);
    wr(LAIS_A_CTRL, 32'h3);
    chk({31'h0, waiting_ind}, 32'h1);
    trig();
    rd(LAIS_A_STAT, 32'h2, 32'h2);
    cyc(4);
    chk(exp_prn.size(), 32'h0);
    report_and_stop();
  end

  initial
  begin
    cyc(20000);
    error_cnt++;
    report_and_stop();
  end
endmodule
